// ---- bawc_top.sv ----
// Break and wait control: reset priority, break vector forcing, flag protection
// in break, wait/stop entry and wake. Assumes one clock and an APB master.
//
// The APB slave port and the address map were chosen for this implementation.
`timescale 1ns/10ps
module bawc_top
(
  input  wire logic                           pclk,
  input  wire logic                           presetn,
  input  wire logic                           psel,
  input  wire logic                           penable,
  input  wire logic                           pwrite,
  input  wire logic [11:0]                    paddr,
  input  wire logic [31:0]                    pwdata,
  output logic [31:0]                         prdata,
  output logic                                pready,
  output logic                                pslverr,
  input  wire logic [3:0]                     rst_src,
  input  wire logic                           brk_req,
  input  wire logic [bawc_pkg::BAWC_NSRC-1:0] irq,
  input  wire bawc_pkg::bawc_cpu_req_t        cpu_req,
  input  wire logic                           flag_clr_req,
  input  wire logic                           step1_seen,
  output bawc_pkg::bawc_cpu_ctl_t             cpu_ctl,
  output logic                                sys_rst_out,
  output logic                                break_mode,
  output logic                                flag_clr_ok,
  output logic                                step1_keep,
  output logic                                periph_clk_en,
  output logic                                watchdog_run
);

  bawc_pkg::bawc_state_t state_reg;
  bawc_pkg::bawc_state_t state_next;

  logic       break_clear_enable;
  logic       break_during_wait_flag;
  logic       watchdog_disable_option;
  logic       any_rst;
  logic       apb_wr;
  logic       apb_rd;
  logic       held;
  logic [4:0] held_vec;
  logic       wake_irq;
  logic       brk_pend_reg;
  logic [31:0] rdata_next;
  logic       addr_ok;

  // Every reset source is OR-ed: equal rank, nothing to arbitrate
  assign any_rst = |rst_src;
  assign apb_wr  = psel && penable && pwrite;
  assign apb_rd  = psel && penable && !pwrite;
  assign addr_ok = (paddr == bawc_pkg::BAWC_FLAG_CTRL_OFS) ||
                   (paddr == bawc_pkg::BAWC_STATUS_OFS) ||
                   (paddr == bawc_pkg::BAWC_OPTION_OFS);
  assign wake_irq = |irq;

  bawc_int_latch u_latch
  (
    .pclk     (pclk),
    .presetn  (presetn),
    .sys_rst  (any_rst),
    .irq      (irq),
    .take     (cpu_req.fetch_req && !cpu_req.int_mask && state_reg == bawc_pkg::BAWC_RUN),
    .serviced (cpu_req.serviced),
    .mask_clr (cpu_ctl.clr_mask),
    .held     (held),
    .held_vec (held_vec)
  );

  // Low-power state machine
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      bawc_pkg::BAWC_RUN:
      begin
        if (cpu_req.wait_exec)
          state_next = bawc_pkg::BAWC_WAIT;
        else if (cpu_req.stop_exec)
          state_next = bawc_pkg::BAWC_STOP;
      end
      bawc_pkg::BAWC_WAIT:
      begin
        // Break and interrupts both end wait; reset is handled above all
        if (brk_req || wake_irq)
          state_next = bawc_pkg::BAWC_WAKE;
      end
      bawc_pkg::BAWC_STOP:
      begin
        if (brk_req || wake_irq)
          state_next = bawc_pkg::BAWC_WAKE;
      end
      bawc_pkg::BAWC_WAKE:
        state_next = bawc_pkg::BAWC_RUN;
      default:
        state_next = bawc_pkg::BAWC_RUN;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state_reg <= bawc_pkg::BAWC_RUN;
    else if (any_rst)
      state_reg <= bawc_pkg::BAWC_RUN;
    else
      state_reg <= state_next;
  end

  // CPU control outputs, all registered
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cpu_ctl <= '0;
    end
    else if (any_rst)
    begin
      cpu_ctl            <= '0;
      cpu_ctl.vec_valid  <= 1'b1;
      cpu_ctl.vec_sel    <= bawc_pkg::BAWC_VEC_RST;
    end
    else
    begin
      // Clock gate: off in wait/stop, back on in the wake cycle ahead of stacking
      cpu_ctl.cpu_clk_en <= (state_next == bawc_pkg::BAWC_RUN) || (state_next == bawc_pkg::BAWC_WAKE);
      cpu_ctl.clr_mask   <= (state_reg == bawc_pkg::BAWC_RUN) &&
                            (cpu_req.wait_exec || cpu_req.stop_exec);
      // Stacking follows the wake cycle, one cycle after the wait instruction's end
      cpu_ctl.stack_go   <= (state_reg == bawc_pkg::BAWC_WAKE);
      if (brk_req || brk_pend_reg)
      begin
        cpu_ctl.vec_valid <= 1'b1;
        cpu_ctl.vec_sel   <= bawc_pkg::BAWC_VEC_TRAP;
      end
      else if (held)
      begin
        cpu_ctl.vec_valid <= 1'b1;
        cpu_ctl.vec_sel   <= held_vec;
      end
      else
      begin
        cpu_ctl.vec_valid <= 1'b0;
        cpu_ctl.vec_sel   <= bawc_pkg::BAWC_VEC_NONE;
      end
    end
  end

  // Break mode tracking: trap pending until the CPU's next vector fetch, break mode held until serviced
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      brk_pend_reg <= 1'b0;
      break_mode   <= 1'b0;
    end
    else if (any_rst)
    begin
      brk_pend_reg <= 1'b0;
      break_mode   <= 1'b0;
    end
    else
    begin
      if (brk_req)
        brk_pend_reg <= 1'b1;
      else if (cpu_req.fetch_req)
        brk_pend_reg <= 1'b0;
      if (brk_req)
        break_mode <= 1'b1;
      else if (cpu_req.serviced)
        break_mode <= 1'b0;
    end
  end

  // Flag protection toward peripherals; the block never restores a cleared flag
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      flag_clr_ok <= 1'b0;
      step1_keep  <= 1'b0;
    end
    else
    begin
      // Clear allowed outside break, or in break with the enable set
      flag_clr_ok <= flag_clr_req && (!break_mode || break_clear_enable);
      // First step seen during break with the enable clear is kept so the post-break second step clears
      step1_keep  <= step1_seen && break_mode && !break_clear_enable;
    end
  end

  // Peripheral clocks keep running except in stop; watchdog per option
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      periph_clk_en <= 1'b1;
      watchdog_run  <= 1'b0;
      sys_rst_out   <= 1'b1;
    end
    else
    begin
      // Reset forces RUN, so clocks must not stay gated for a cycle after it
      periph_clk_en <= any_rst || (state_next != bawc_pkg::BAWC_STOP);
      watchdog_run  <= !watchdog_disable_option && (any_rst || (state_next != bawc_pkg::BAWC_STOP));
      sys_rst_out   <= any_rst;
    end
  end

  // Software registers; a break ending wait sets the sticky flag, set beats clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      break_clear_enable      <= bawc_pkg::BAWC_BCE_RST;
      watchdog_disable_option <= bawc_pkg::BAWC_WDD_RST;
      break_during_wait_flag  <= 1'b0;
    end
    else
    begin
      if (apb_wr && paddr == bawc_pkg::BAWC_FLAG_CTRL_OFS)
        break_clear_enable <= pwdata[bawc_pkg::BAWC_BCE_BIT];
      if (apb_wr && paddr == bawc_pkg::BAWC_OPTION_OFS)
        watchdog_disable_option <= pwdata[bawc_pkg::BAWC_WDD_BIT];
      if (state_reg == bawc_pkg::BAWC_WAIT && brk_req)
        break_during_wait_flag <= 1'b1;
      else if (apb_wr && paddr == bawc_pkg::BAWC_STATUS_OFS && !pwdata[bawc_pkg::BAWC_BDW_BIT])
        break_during_wait_flag <= 1'b0;
    end
  end

  always_comb
  begin
    rdata_next = 32'h0000_0000;
    case (paddr)
      bawc_pkg::BAWC_FLAG_CTRL_OFS: rdata_next[bawc_pkg::BAWC_BCE_BIT] = break_clear_enable;
      bawc_pkg::BAWC_STATUS_OFS:    rdata_next[bawc_pkg::BAWC_BDW_BIT] = break_during_wait_flag;
      bawc_pkg::BAWC_OPTION_OFS:    rdata_next[bawc_pkg::BAWC_WDD_BIT] = watchdog_disable_option;
      default:                      rdata_next = 32'h0000_0000;
    endcase
  end

  // Zero-wait APB: pready registered high in the access cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
    else
    begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !addr_ok;
      if (psel && !penable && !pwrite)
        prdata <= rdata_next;
      else if (apb_rd)
        prdata <= prdata;
      else
        prdata <= 32'h0000_0000;
    end
  end

endmodule

// ---- bawc_pkg.sv ----
// Package for the break and wait control block: register map, field positions,
// reset values, state and carrier types. Assumes an APB slave with 32-bit data.
package bawc_pkg;

  localparam logic [11:0] BAWC_FLAG_CTRL_OFS  = 12'h000;
  localparam logic [11:0] BAWC_STATUS_OFS     = 12'h004;
  localparam logic [11:0] BAWC_OPTION_OFS     = 12'h008;

  localparam int BAWC_BCE_BIT   = 7;
  localparam int BAWC_BDW_BIT   = 1;
  localparam int BAWC_WDD_BIT   = 0;

  localparam logic BAWC_BCE_RST = 1'b0;
  localparam logic BAWC_WDD_RST = 1'b0;

  localparam int          BAWC_NSRC     = 8;
  localparam logic [4:0]  BAWC_VEC_NONE = 5'h00;
  localparam logic [4:0]  BAWC_VEC_TRAP = 5'h1e;
  localparam logic [4:0]  BAWC_VEC_RST  = 5'h1f;
  localparam int          BAWC_STACK_DLY = 1;

  typedef enum logic [1:0] {
    BAWC_RUN,
    BAWC_WAIT,
    BAWC_STOP,
    BAWC_WAKE
  } bawc_state_t;

  // Request from the CPU side
  typedef struct packed {
    logic       wait_exec;
    logic       stop_exec;
    logic       int_mask;
    logic       serviced;
    logic       fetch_req;
  } bawc_cpu_req_t;

  // Commands back to the CPU
  typedef struct packed {
    logic       cpu_clk_en;
    logic       clr_mask;
    logic       stack_go;
    logic       vec_valid;
    logic [4:0] vec_sel;
  } bawc_cpu_ctl_t;

endpackage

// ---- bawc_int_latch.sv ----
// Interrupt latch and fixed-priority pick for the break and wait control block.
// Assumes source requests already gated by their enable bits.
`timescale 1ns/10ps
module bawc_int_latch
(
  input  wire logic                           pclk,
  input  wire logic                           presetn,
  input  wire logic                           sys_rst,
  input  wire logic [bawc_pkg::BAWC_NSRC-1:0] irq,
  input  wire logic                           take,
  input  wire logic                           serviced,
  input  wire logic                           mask_clr,
  output logic                                held,
  output logic [4:0]                          held_vec
);

  logic [bawc_pkg::BAWC_NSRC-1:0] first_hot;
  logic [4:0]                     pick_vec;

  // Lowest index wins; one-hot isolate by generate so each source is one stage
  genvar g;
  generate
    for (g = 0; g < bawc_pkg::BAWC_NSRC; g++)
    begin : g_pick
      if (g == 0)
      begin : g_first
        assign first_hot[g] = irq[g];
      end
      else
      begin : g_rest
        assign first_hot[g] = irq[g] & ~|irq[g-1:0];
      end
    end
  endgenerate

  always_comb
  begin
    pick_vec = bawc_pkg::BAWC_VEC_NONE;
    for (int i = bawc_pkg::BAWC_NSRC - 1; i >= 0; i--)
    begin
      if (first_hot[i])
        pick_vec = 5'(i + 1);
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      held     <= 1'b0;
      held_vec <= bawc_pkg::BAWC_VEC_NONE;
    end
    else if (sys_rst)
    begin
      held     <= 1'b0;
      held_vec <= bawc_pkg::BAWC_VEC_NONE;
    end
    else if (held)
    begin
      // No later source displaces a held one regardless of its rank
      if (serviced || mask_clr)
        held <= 1'b0;
    end
    else if (take && |irq)
    begin
      held     <= 1'b1;
      held_vec <= pick_vec;
    end
  end

endmodule

// ---- bawc_checker.sv ----
// Port-level checks for bawc_top: reset, break, flag gating, wait and wake.
// Bound to bawc_top from the testbench top file.
`timescale 1ns/10ps
module bawc_checker
(
  input wire logic                    pclk,
  input wire logic                    presetn,
  input wire logic [3:0]              rst_src,
  input wire logic                    brk_req,
  input wire logic [7:0]              irq,
  input wire logic                    flag_clr_req,
  input wire bawc_pkg::bawc_cpu_ctl_t cpu_ctl,
  input wire bawc_pkg::bawc_cpu_req_t cpu_req,
  input wire logic                    sys_rst_out,
  input wire logic                    break_mode,
  input wire logic                    flag_clr_ok,
  input wire logic                    periph_clk_en
);
  logic waiting;
  logic in_stop;
  wire  quiet = !(|rst_src) && !brk_req;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Tracks low power from the mask-clear pulse until the CPU clock returns
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      waiting <= 1'b0;
    else if (|rst_src)
      waiting <= 1'b0;
    else if (cpu_ctl.clr_mask)
      waiting <= 1'b1;
    else if (cpu_ctl.cpu_clk_en)
      waiting <= 1'b0;
  // Stop is the only state allowed to gate the peripheral clocks
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      in_stop <= 1'b0;
    else if (cpu_req.stop_exec && !cpu_req.wait_exec && !waiting && !(|rst_src))
      in_stop <= 1'b1;
    else if (cpu_ctl.cpu_clk_en)
      in_stop <= 1'b0;
  chk_reset_vec:
    assert property (|rst_src |=> cpu_ctl.vec_valid && cpu_ctl.vec_sel == bawc_pkg::BAWC_VEC_RST && sys_rst_out)
    else $error("reset vector missing");
  chk_break_trap:
    assert property (brk_req && !(|rst_src) |=> cpu_ctl.vec_sel == bawc_pkg::BAWC_VEC_TRAP)
    else $error("break did not force trap vector");
  chk_clear_cause:
    assert property (flag_clr_ok |-> $past(flag_clr_req))
    else $error("flag clear without request");
  chk_clear_free:
    assert property (flag_clr_req && !break_mode && quiet |=> flag_clr_ok)
    else $error("flag clear refused outside break");
  chk_wait_entry:
    assert property (cpu_ctl.clr_mask |-> !cpu_ctl.cpu_clk_en)
    else $error("mask cleared with CPU clock running");
  chk_periph_run:
    assert property (!in_stop |-> periph_clk_en)
    else $error("peripheral clock stopped");
  chk_irq_wake:
    assert property (waiting && !cpu_ctl.cpu_clk_en && |irq && quiet |=> cpu_ctl.cpu_clk_en ##1 cpu_ctl.stack_go)
    else $error("interrupt wake timing wrong");
  chk_brk_wake:
    assert property (waiting && !cpu_ctl.cpu_clk_en && brk_req && !(|rst_src) |=> cpu_ctl.cpu_clk_en)
    else $error("break did not end wait");
  chk_wait_hold:
    assert property (waiting && !cpu_ctl.cpu_clk_en && !(|irq) && quiet |=> !cpu_ctl.cpu_clk_en)
    else $error("CPU clock restarted without cause");
  cover property (cpu_ctl.stack_go);
  cover property (waiting && brk_req);
  cover property (flag_clr_req && break_mode);
endmodule

// ---- bawc_cpu_model.sv ----
// CPU core stand-in: takes offered vectors and keeps the interrupt mask.
// Driven by bawc_top cpu_ctl; the testbench asks for wait, stop and service.
`timescale 1ns/10ps
module bawc_cpu_model
(
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire bawc_pkg::bawc_cpu_ctl_t cpu_ctl,
  input  wire logic                    do_wait,
  input  wire logic                    do_stop,
  input  wire logic                    do_svc,
  output bawc_pkg::bawc_cpu_req_t      cpu_req
);
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      cpu_req <= '0;
    else
    begin
      cpu_req.wait_exec <= do_wait;
      cpu_req.stop_exec <= do_stop;
      cpu_req.serviced  <= do_svc;
      // Fetch pulses every other cycle while a vector is offered, never a held strobe
      cpu_req.fetch_req <= cpu_ctl.vec_valid && !cpu_req.fetch_req;
      if (cpu_ctl.clr_mask)
        cpu_req.int_mask <= 1'b0;
      else if (cpu_ctl.stack_go)
        cpu_req.int_mask <= 1'b1;
    end
endmodule

// ---- bawc_top_test.sv ----
// Testbench for bawc_top: APB master, CPU stand-in, expected-value queue.
// Assumes bawc_pkg, bawc_cpu_model and bawc_checker are compiled first.
`timescale 1ns/10ps
module bawc_top_test;
  logic                    pclk = 1'b0;
  logic                    presetn = 1'b0;
  logic                    psel = 1'b0;
  logic                    penable = 1'b0;
  logic                    pwrite = 1'b0;
  logic [11:0]             paddr = 12'h000;
  logic [31:0]             pwdata = 32'h0;
  logic [31:0]             prdata;
  logic                    pready;
  logic                    pslverr;
  logic [3:0]              rst_src = 4'h0;
  logic                    brk_req = 1'b0;
  logic [7:0]              irq = 8'h00;
  logic                    clr_req = 1'b0;
  logic                    step1 = 1'b0;
  logic                    do_wait = 1'b0;
  logic                    do_stop = 1'b0;
  logic                    do_svc = 1'b0;
  logic                    brk_on;
  logic                    step1_kept;
  logic                    clr_ok;
  logic                    wd_run;
  logic                    per_clk;
  logic                    sys_rst;
  bawc_pkg::bawc_cpu_req_t cpu_req;
  bawc_pkg::bawc_cpu_ctl_t ctl;
  logic [32:0]             exp_q[$];
  logic [31:0]             seed = 32'h6e0f;
  int                      err_total = 0;
  int                      n_compared = 0;
  int                      cyc = 0;
  initial
    forever #10 pclk = ~pclk;
  bawc_top dut
  (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rst_src(rst_src), .brk_req(brk_req), .irq(irq), .cpu_req(cpu_req), .flag_clr_req(clr_req),
    .step1_seen(step1), .cpu_ctl(ctl), .sys_rst_out(sys_rst), .break_mode(brk_on),
    .flag_clr_ok(clr_ok), .step1_keep(step1_kept), .periph_clk_en(per_clk), .watchdog_run(wd_run)
  );
  bawc_cpu_model cpu
  (
    .pclk(pclk), .presetn(presetn), .cpu_ctl(ctl), .do_wait(do_wait), .do_stop(do_stop),
    .do_svc(do_svc), .cpu_req(cpu_req)
  );
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      $display("unexpected %s: expected %h seen %h", n, e, g);
      err_total++;
    end
  endtask
  task automatic close_out;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Expectation is {pslverr, prdata}; write data part is ignored
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [32:0] e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    exp_q.push_back(e);
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic clear_try(input logic e);
    @(posedge pclk) clr_req <= 1'b1;
    @(posedge pclk) clr_req <= 1'b0;
    @(negedge pclk);
    chk("flag_clr_ok", e, clr_ok);
  endtask
  task automatic sleep(input logic stop);
    @(posedge pclk);
    do_wait <= !stop;
    do_stop <= stop;
    @(posedge pclk);
    do_wait <= 1'b0;
    do_stop <= 1'b0;
    @(posedge pclk);
    @(negedge pclk);
    chk("clr_mask", 1, ctl.clr_mask);
    chk("cpu_clk_en", 0, ctl.cpu_clk_en);
  endtask
  task automatic brk;
    @(posedge pclk) brk_req <= 1'b1;
    @(posedge pclk) brk_req <= 1'b0;
    @(negedge pclk);
    chk("vec_sel", bawc_pkg::BAWC_VEC_TRAP, ctl.vec_sel);
  endtask
  task automatic service;
    @(posedge pclk) do_svc <= 1'b1;
    @(posedge pclk) do_svc <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask
  always @(posedge pclk)
    if (psel && penable && pready && exp_q.size() > 0)
    begin
      chk("pslverr", exp_q[0][32], pslverr);
      if (!pwrite)
        chk("prdata", exp_q[0][31:0], prdata);
      void'(exp_q.pop_front());
    end
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      err_total++;
      close_out;
    end
  end
  initial
  begin
    repeat (10) @(posedge pclk);
    chk("periph_clk_en", 1, per_clk);
    chk("sys_rst_out", 1, sys_rst);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    apb(0, 12'h000, 0, 33'h0);
    apb(0, 12'h004, 0, 33'h0);
    apb(0, 12'h008, 0, 33'h0);
    apb(1, 12'h00c, 0, {1'b1, 32'h0});
    repeat (2)
    begin
      seed = xs(seed);
      apb(1, 12'h008, seed, 33'h0);
      apb(0, 12'h008, 0, {32'h0, seed[0]});
      chk("watchdog_run", !seed[0], wd_run);
    end
    step1 <= 1'b1;
    brk();
    chk("break_mode", 1, brk_on);
    clear_try(0);
    chk("step1_keep", 1, step1_kept);
    apb(1, 12'h000, 32'h80, 33'h0);
    apb(0, 12'h000, 0, 33'h80);
    clear_try(1);
    apb(1, 12'h000, 0, 33'h0);
    service();
    chk("break_mode", 0, brk_on);
    chk("step1_keep", 0, step1_kept);
    clear_try(1);
    sleep(0);
    repeat (3) @(posedge pclk);
    chk("periph_clk_en", 1, per_clk);
    seed = xs(seed);
    irq <= seed[7:0] | 8'h01;
    @(posedge pclk);
    @(negedge pclk);
    chk("cpu_clk_en", 1, ctl.cpu_clk_en);
    @(negedge pclk);
    chk("stack_go", 1, ctl.stack_go);
    @(posedge pclk) irq <= 8'h00;
    service();
    sleep(0);
    brk();
    chk("cpu_clk_en", 1, ctl.cpu_clk_en);
    apb(0, 12'h004, 0, 33'h2);
    apb(1, 12'h004, 0, 33'h0);
    apb(0, 12'h004, 0, 33'h0);
    service();
    sleep(1);
    for (int i = 0; i < 4; i++)
    begin
      @(posedge pclk) rst_src <= 4'(4'h1 << i);
      brk_req <= i[0];
      @(posedge pclk) rst_src <= 4'h0;
      brk_req <= 1'b0;
      @(negedge pclk);
      chk("vec_sel", bawc_pkg::BAWC_VEC_RST, ctl.vec_sel);
      chk("sys_rst_out", 1, sys_rst);
      repeat (8) @(posedge pclk);
    end
    close_out();
  end
endmodule
bind bawc_top bawc_checker u_chk
(
  .pclk(pclk), .presetn(presetn), .rst_src(rst_src), .brk_req(brk_req), .irq(irq),
  .flag_clr_req(flag_clr_req), .cpu_ctl(cpu_ctl), .cpu_req(cpu_req), .sys_rst_out(sys_rst_out),
  .break_mode(break_mode), .flag_clr_ok(flag_clr_ok), .periph_clk_en(periph_clk_en)
);
